// ===== clpv_defs.vh
`ifndef CLPV_DEFS_VH
`define CLPV_DEFS_VH
`define CLPV_ADDR_MODE      12'h000
`define CLPV_ADDR_DEADBAND  12'h004
`define CLPV_ADDR_FOLLOW    12'h008
`define CLPV_ADDR_RETRY_MS  12'h00C
`define CLPV_ADDR_ATTEMPTS  12'h010
`define CLPV_ADDR_SCALE     12'h014
`define CLPV_ADDR_EXEC_FMT  12'h018
`define CLPV_ADDR_CMD       12'h01C
`define CLPV_ADDR_STATUS    12'h020
`define CLPV_ADDR_ABS_POS   12'h024
`define CLPV_ADDR_ENC_POS   12'h028
`define CLPV_ADDR_ATT_LEFT  12'h02C
`define CLPV_ADDR_TARGET    12'h030
`define CLPV_CMD_PROG_START 0
`define CLPV_CMD_MOVE       1
`define CLPV_CMD_SET_HOME   2
`define CLPV_ST_BUSY        0
`define CLPV_ST_CL_ERR      1
`define CLPV_ST_FAULT       2
`define CLPV_ST_ABS_BAD     3
`define CLPV_ST_STATE       4
`define CLPV_EXEC_DRY_BIT   8
`define CLPV_RST_MODE       2'h0
`define CLPV_RST_DEADBAND   16'h0005
`define CLPV_RST_FOLLOW     16'h000A
`define CLPV_RST_RETRY_MS   16'h0064
`define CLPV_RST_ATTEMPTS   16'h0064
`define CLPV_RST_SCALE      4'h4
`define CLPV_CLK_HZ         40000000
`define CLPV_CYC_PER_MS     (`CLPV_CLK_HZ / 1000)
`define CLPV_SCALE_MULT     4'h5
`endif

// ===== clpv_delay_timer.v
`include "clpv_defs.vh"
module clpv_delay_timer #(
  parameter CYC_PER_MS = `CLPV_CYC_PER_MS
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        start,
  input  wire [15:0] delay_ms,
  output wire        busy,
  output reg         done
);
  reg [15:0] ms_left;
  reg [31:0] cyc;
  reg        running;
  assign busy = running;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_left <= 16'h0000;
      cyc     <= 32'h00000000;
      running <= 1'b0;
      done    <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        running <= 1'b1;
        ms_left <= delay_ms;
        cyc     <= 32'h00000000;
      end else if (running) begin
        if (ms_left == 16'h0000) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else if (cyc == CYC_PER_MS - 1) begin
          cyc     <= 32'h00000000;
          ms_left <= ms_left - 16'h0001;
        end else begin
          cyc <= cyc + 32'h00000001;
        end
      end
    end
  end
endmodule // clpv_delay_timer

// ===== clpv_drive_model.sv
module clpv_drive_model (
  input  logic        pclk,
  input  logic        presetn,
  input  logic        move_req,
  input  logic [31:0] move_target,
  input  logic        halt_now,
  input  logic        motion_enable,
  input  logic        slip,
  input  logic        kick,
  input  logic        zero_pos,
  output logic        step_pulse,
  output logic        step_dir_cw,
  output logic        motion_done,
  output logic        enc_up,
  output logic        enc_down
);
  timeunit 1ns;
  timeprecision 100ps;
  int   pos;
  int   tgt;
  logic act;
  logic ph;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos <= 0; tgt <= 0; act <= 0; ph <= 0; step_pulse <= 0; step_dir_cw <= 0;
      motion_done <= 0; enc_up <= 0; enc_down <= 0;
    end else begin
      step_pulse <= 0; motion_done <= 0; enc_down <= 0;
      enc_up <= kick && !act;
      ph <= ~ph;
      if (zero_pos) pos <= 0;
      if (halt_now) act <= 0;
      else if (move_req && motion_enable) begin
        act <= 1; tgt <= move_target;
      end else if (act && ph) begin
        if (pos == tgt) begin
          act <= 0; motion_done <= 1;
        end else begin
          // Slip models a stalled shaft: steps go out, encoder stays put
          step_pulse <= 1; step_dir_cw <= tgt > pos; pos <= pos + (tgt > pos ? 1 : -1);
          enc_up <= !slip && tgt > pos; enc_down <= !slip && tgt < pos;
        end
      end
    end
  end
endmodule // clpv_drive_model

// ===== clpv_enc_scale.v
`include "clpv_defs.vh"
module clpv_enc_scale (
  input  wire        [3:0]  scale,
  input  wire signed [31:0] quad_count,
  output reg  signed [31:0] enc_count
);
  always @* begin
    if (scale == `CLPV_SCALE_MULT)
      enc_count = quad_count * 5;
    else if (scale == 4'h0)
      enc_count = quad_count;
    else
      enc_count = quad_count / $signed({28'h0000000, scale});
  end
endmodule // clpv_enc_scale

// ===== clpv_top.v
// Contract
// - Modes 1 to 3 hold the stopped motor inside the in-position deadband.
// - Error beyond the deadband at standstill starts a correction to its centre; this implementation sets the move target to enc_count instead.
// - Retry delay is the least spacing between two correction attempts; the code can start a standstill correction before tmr_busy rises.
// - Retry delay timing starts when motion has finished, not at issue.
// - Following error in motion flags an error and stops without ramp.
// - After a following error stop, wait out the retry delay doing nothing.
// - After the delay, end the cycle if mode is 1 or attempts ran out.
// - Ending on a closed-loop error copies encoder position into absolute counter.
// - A closed-loop error lights the fault output.
// - Program start or a new motion cycle clears the closed-loop error.
// - Otherwise restart the current cycle and take one attempt off the count.
// - Any jog, step or index cycle reloads the attempt count from its limit.
// - Absolute counter follows electrical position during every motion.
// - Fault shows drive, rate, soft or hard limit, program or closed-loop errors.
// - Motion busy is high whenever the motor has been commanded to move.
// - Dry run leading digit 1 blocks motion; 0 allows it again.
// - Mode selector takes 0 to 3; 0 turns verification off.
// - Scale 5 multiplies quadrature count by five, 0 passes it through unchanged, other values divide.
//
// The address map and the APB register port were chosen for this implementation.
`include "clpv_defs.vh"
module clpv_top #(
  parameter CYC_PER_MS = `CLPV_CYC_PER_MS
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        step_pulse,
  input  wire        step_dir_cw,
  input  wire        motion_done,
  input  wire        enc_up,
  input  wire        enc_down,
  input  wire        drive_not_ready,
  input  wire        rate_limit_err,
  input  wire        sw_limit_cw,
  input  wire        sw_limit_ccw,
  input  wire        hw_limit_cw,
  input  wire        hw_limit_ccw,
  input  wire        program_err,
  input  wire        motion_clear,
  input  wire        cycle_kind_jog_step_index,
  output reg         move_req,
  output reg  [31:0] move_target,
  output reg         halt_now,
  output wire        motion_enable,
  output wire        motion_busy,
  output wire        fault
);
  localparam S_IDLE    = 3'h0;
  localparam S_MOVE    = 3'h1;
  localparam S_WAIT    = 3'h2;
  localparam S_DECIDE  = 3'h3;
  localparam S_CORRECT = 3'h4;

  reg  [1:0]  closed_loop_mode_select;
  reg  [15:0] in_position_deadband;
  reg  [15:0] following_error_limit;
  reg  [15:0] correction_retry_delay;
  reg  [15:0] correction_attempt_limit;
  reg  [3:0]  encoder_scale_factor;
  reg  [11:0] execution_format_setting;
  reg  [15:0] attempts_left;
  reg  [31:0] abs_pos;
  reg  [31:0] quad_count;
  reg  [31:0] cycle_target;
  reg  [2:0]  state;
  reg         cl_err;
  reg         abs_bad;
  reg         motion_on;
  reg         tmr_start;
  reg         follow_trip;
  wire [31:0] enc_count;
  wire        tmr_done;
  wire        tmr_busy;
  wire        wr;
  wire        dry_run;
  wire [31:0] diff;
  wire [31:0] err_mag;
  wire        verify_on;
  wire        sw_move;
  wire        prog_start;

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr      = psel && penable && pwrite;
  assign dry_run = execution_format_setting[`CLPV_EXEC_DRY_BIT];
  assign motion_enable = !dry_run;
  assign verify_on = closed_loop_mode_select != 2'h0;
  assign diff    = enc_count - abs_pos;
  assign err_mag = diff[31] ? (32'h00000000 - diff) : diff;
  assign sw_move    = wr && (paddr == `CLPV_ADDR_CMD) && pwdata[`CLPV_CMD_MOVE];
  assign prog_start = wr && (paddr == `CLPV_ADDR_CMD) && pwdata[`CLPV_CMD_PROG_START];
  assign motion_busy = motion_on || move_req;
  assign fault = drive_not_ready || rate_limit_err || sw_limit_cw || sw_limit_ccw
              || hw_limit_cw || hw_limit_ccw || program_err || cl_err;

  clpv_enc_scale u_scale (
    .scale      (encoder_scale_factor),
    .quad_count (quad_count),
    .enc_count  (enc_count)
  );

  clpv_delay_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .start    (tmr_start),
    .delay_ms (correction_retry_delay),
    .busy     (tmr_busy),
    .done     (tmr_done)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      closed_loop_mode_select  <= `CLPV_RST_MODE;
      in_position_deadband     <= `CLPV_RST_DEADBAND;
      following_error_limit    <= `CLPV_RST_FOLLOW;
      correction_retry_delay   <= `CLPV_RST_RETRY_MS;
      correction_attempt_limit <= `CLPV_RST_ATTEMPTS;
      encoder_scale_factor     <= `CLPV_RST_SCALE;
      execution_format_setting <= 12'h000;
      cycle_target             <= 32'h00000000;
    end else if (ce && wr) begin
      if (paddr == `CLPV_ADDR_MODE)
        closed_loop_mode_select <= pwdata[1:0];
      else if (paddr == `CLPV_ADDR_DEADBAND)
        in_position_deadband <= pwdata[15:0];
      else if (paddr == `CLPV_ADDR_FOLLOW)
        following_error_limit <= pwdata[15:0];
      else if (paddr == `CLPV_ADDR_RETRY_MS)
        correction_retry_delay <= pwdata[15:0];
      else if (paddr == `CLPV_ADDR_ATTEMPTS)
        correction_attempt_limit <= pwdata[15:0];
      else if (paddr == `CLPV_ADDR_SCALE)
        encoder_scale_factor <= pwdata[3:0];
      else if (paddr == `CLPV_ADDR_EXEC_FMT)
        execution_format_setting <= pwdata[11:0];
      else if (paddr == `CLPV_ADDR_TARGET)
        cycle_target <= pwdata;
    end
  end

  // Encoder count is free running; abs_pos tracks steps actually issued
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quad_count <= 32'h00000000;
    end else if (ce) begin
      if (wr && paddr == `CLPV_ADDR_CMD && pwdata[`CLPV_CMD_SET_HOME])
        quad_count <= 32'h00000000;
      else if (enc_up && !enc_down)
        quad_count <= quad_count + 32'h00000001;
      else if (enc_down && !enc_up)
        quad_count <= quad_count - 32'h00000001;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state         <= S_IDLE;
      abs_pos       <= 32'h00000000;
      attempts_left <= `CLPV_RST_ATTEMPTS;
      cl_err        <= 1'b0;
      abs_bad       <= 1'b0;
      motion_on     <= 1'b0;
      move_req      <= 1'b0;
      move_target   <= 32'h00000000;
      halt_now      <= 1'b0;
      tmr_start     <= 1'b0;
      follow_trip   <= 1'b0;
    end else if (ce) begin
      move_req  <= 1'b0;
      halt_now  <= 1'b0;
      tmr_start <= 1'b0;
      if (motion_on && step_pulse)
        abs_pos <= step_dir_cw ? abs_pos + 32'h00000001
                               : abs_pos - 32'h00000001;
      if (wr && paddr == `CLPV_ADDR_CMD && pwdata[`CLPV_CMD_SET_HOME]) begin
        abs_pos <= 32'h00000000;
        abs_bad <= 1'b0;
      end
      if (motion_on && (motion_clear || hw_limit_cw || hw_limit_ccw))
        abs_bad <= 1'b1;
      if (prog_start)
        cl_err <= 1'b0;
      if (cycle_kind_jog_step_index)
        attempts_left <= correction_attempt_limit;
      case (state)
        S_IDLE: begin
          if (sw_move && !dry_run) begin
            cl_err        <= 1'b0;
            attempts_left <= correction_attempt_limit;
            move_req      <= 1'b1;
            move_target   <= cycle_target;
            motion_on     <= 1'b1;
            follow_trip   <= 1'b0;
            state         <= S_MOVE;
          end else if (verify_on && !dry_run && !cl_err && !tmr_busy
                       && err_mag > {16'h0000, in_position_deadband}) begin
            move_req    <= 1'b1;
            move_target <= enc_count;
            abs_pos     <= enc_count;
            motion_on   <= 1'b1;
            state       <= S_CORRECT;
          end
        end
        S_MOVE, S_CORRECT: begin
          if (verify_on && err_mag > {16'h0000, following_error_limit}) begin
            halt_now    <= 1'b1;
            motion_on   <= 1'b0;
            follow_trip <= 1'b1;
            tmr_start   <= 1'b1;
            state       <= S_WAIT;
          end else if (motion_done) begin
            motion_on   <= 1'b0;
            tmr_start   <= verify_on;
            state       <= S_IDLE;
          end
        end
        S_WAIT: begin
          if (tmr_done)
            state <= S_DECIDE;
        end
        S_DECIDE: begin
          if (closed_loop_mode_select == 2'h1 || attempts_left == 16'h0000) begin
            cl_err  <= 1'b1;
            abs_pos <= enc_count;
            state   <= S_IDLE;
          end else begin
            attempts_left <= attempts_left - 16'h0001;
            abs_pos       <= enc_count;
            move_req      <= 1'b1;
            move_target   <= cycle_target;
            motion_on     <= 1'b1;
            state         <= S_MOVE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  always @* begin
    prdata = 32'h00000000;
    if (!(psel && !pwrite)) prdata = 32'h00000000;
    else if (paddr == `CLPV_ADDR_MODE)     prdata = {30'h00000000, closed_loop_mode_select};
    else if (paddr == `CLPV_ADDR_DEADBAND) prdata = {16'h0000, in_position_deadband};
    else if (paddr == `CLPV_ADDR_FOLLOW)   prdata = {16'h0000, following_error_limit};
    else if (paddr == `CLPV_ADDR_RETRY_MS) prdata = {16'h0000, correction_retry_delay};
    else if (paddr == `CLPV_ADDR_ATTEMPTS) prdata = {16'h0000, correction_attempt_limit};
    else if (paddr == `CLPV_ADDR_SCALE)    prdata = {28'h0000000, encoder_scale_factor};
    else if (paddr == `CLPV_ADDR_EXEC_FMT) prdata = {20'h00000, execution_format_setting};
    else if (paddr == `CLPV_ADDR_STATUS)
      prdata = {25'h0000000, state, abs_bad, fault, cl_err, motion_busy};
    else if (paddr == `CLPV_ADDR_ABS_POS)  prdata = abs_pos;
    else if (paddr == `CLPV_ADDR_ENC_POS)  prdata = enc_count;
    else if (paddr == `CLPV_ADDR_ATT_LEFT) prdata = {16'h0000, attempts_left};
    else if (paddr == `CLPV_ADDR_TARGET)   prdata = cycle_target;
  end
endmodule // clpv_top

// ===== clpv_top_properties.sv
`include "clpv_defs.vh"
module clpv_top_chk #(
  parameter CYC_PER_MS = 40000
) (
  input logic        pclk,
  input logic        presetn,
  input logic        ce,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        drive_not_ready,
  input logic        rate_limit_err,
  input logic        sw_limit_cw,
  input logic        sw_limit_ccw,
  input logic        hw_limit_cw,
  input logic        hw_limit_ccw,
  input logic        program_err,
  input logic        move_req,
  input logic        halt_now,
  input logic        motion_enable,
  input logic        motion_busy,
  input logic        fault
);
  wire any_err = drive_not_ready | rate_limit_err | sw_limit_cw | sw_limit_ccw |
                 hw_limit_cw | hw_limit_ccw | program_err;
  wire dry_w   = pwdata[`CLPV_EXEC_DRY_BIT];
  wire exec_wr = psel && penable && pwrite && ce && paddr == `CLPV_ADDR_EXEC_FMT;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_fault_inputs: assert property (any_err |-> fault)
    else $error("fault low with an error input high");
  chk_busy_move: assert property (move_req |-> motion_busy)
    else $error("move issued without busy");
  chk_dry_blocks: assert property (!motion_enable |-> !move_req)
    else $error("move issued in dry run");
  chk_exec_write: assert property (exec_wr |=> motion_enable == !$past(dry_w))
    else $error("motion enable does not follow dry run bit");
  chk_halt_wait: assert property (halt_now |=> !move_req [*4])
    else $error("retry issued before delay");
  chk_halt_motion: assert property (halt_now |-> $past(motion_busy))
    else $error("halt outside motion");
  chk_halt_excl: assert property (halt_now |-> !move_req)
    else $error("halt and move together");
  chk_unmapped_zero: assert property (psel && penable && !pwrite && paddr > 12'h030
    |-> prdata == 32'h0) else $error("unmapped read not zero");
  chk_apb_answer: assert property (psel |-> pready && !pslverr)
    else $error("bus answer not ready or error");
endmodule // clpv_top_chk
bind clpv_top clpv_top_chk #(.CYC_PER_MS(CYC_PER_MS)) i_clpv_top_chk (
  .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .drive_not_ready, .rate_limit_err, .sw_limit_cw, .sw_limit_ccw, .hw_limit_cw,
  .hw_limit_ccw, .program_err, .move_req, .halt_now, .motion_enable, .motion_busy, .fault
);

// ===== tb_top.sv
`include "clpv_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam CPM = 4;
  logic        pclk, presetn, psel, penable, pwrite, cyc_kind, slip, kick, zero_pos;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, t;
  logic [6:0]  errs;
  wire         pready, pslverr, step_pulse, step_dir_cw, motion_done, enc_up, enc_down;
  wire         move_req, halt_now, motion_enable, motion_busy, fault;
  wire  [31:0] prdata, move_target;
  int          err_count, cmp_count, nmov, nhalt, n0, h0, i;
  logic [11:0] ra [7] = '{`CLPV_ADDR_MODE, `CLPV_ADDR_DEADBAND, `CLPV_ADDR_FOLLOW,
                          `CLPV_ADDR_RETRY_MS, `CLPV_ADDR_ATTEMPTS, `CLPV_ADDR_SCALE, 12'h040};
  logic [31:0] rv [7] = '{32'h0, 32'h5, 32'hA, 32'h64, 32'h64, 32'h4, 32'h0};
  logic [3:0]  sc [3] = '{4'h5, 4'h2, 4'h1};
  clpv_top #(.CYC_PER_MS(CPM)) i_clpv_top (
    .pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .step_pulse, .step_dir_cw, .motion_done, .enc_up, .enc_down,
    .drive_not_ready(errs[0]), .rate_limit_err(errs[1]), .sw_limit_cw(errs[2]),
    .sw_limit_ccw(errs[3]), .hw_limit_cw(errs[4]), .hw_limit_ccw(errs[5]),
    .program_err(errs[6]), .motion_clear(1'b0), .cycle_kind_jog_step_index(cyc_kind),
    .move_req, .move_target, .halt_now, .motion_enable, .motion_busy, .fault
  );
  clpv_drive_model i_clpv_drive_model (
    .pclk, .presetn, .move_req, .move_target, .halt_now, .motion_enable, .slip, .kick,
    .zero_pos, .step_pulse, .step_dir_cw, .motion_done, .enc_up, .enc_down
  );
  initial begin
    pclk = 0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (move_req === 1'b1) nmov <= nmov + 1;
    if (halt_now === 1'b1) nhalt <= nhalt + 1;
  end
  task automatic final_report;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    psel <= 0; penable <= 0;
    if (n >= 50) begin
      err_count++;
      final_report();
    end
  endtask
  task automatic wst(input int b, input logic v);
    int k;
    for (k = 0; k < 400; k++) begin
      apb(0, `CLPV_ADDR_STATUS, 0);
      if (rd[b] === v) return;
    end
    err_count++;
    final_report();
  endtask
  // Counter is only trusted after a fresh home on both sides
  task automatic home;
    apb(1, `CLPV_ADDR_CMD, 32'h4);
    zero_pos <= 1;
    @(posedge pclk);
    zero_pos <= 0;
  endtask
  task automatic move(input logic [31:0] tg);
    apb(1, `CLPV_ADDR_TARGET, tg);
    apb(1, `CLPV_ADDR_CMD, 32'h2);
  endtask
  function automatic logic [31:0] enc_exp(input logic [3:0] s, input int q);
    if (s == `CLPV_SCALE_MULT) return q * 5;
    if (s == 4'h0) return q;
    return q / int'(s);
  endfunction
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; errs = 0;
    cyc_kind = 0; slip = 0; kick = 0; zero_pos = 0; err_count = 0; cmp_count = 0;
    nmov = 0; nhalt = 0;
    void'($urandom(77));
    repeat (6) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 7; i++) begin
      apb(0, ra[i], 0);
      chk(rd, rv[i]);
    end
    for (i = 0; i < 8; i++) begin
      errs <= (i < 7) ? 7'h1 << i : 7'($urandom % 127 + 1);
      @(posedge pclk); #1 chk(fault, 1);
      errs <= 0;
      @(posedge pclk); #1 chk(fault, 0);
    end
    for (i = 0; i < 3; i++) begin
      home();
      apb(1, `CLPV_ADDR_SCALE, sc[i]);
      t = ($urandom % 25 + 5) * 2;
      n0 = nmov;
      move(t);
      wst(`CLPV_ST_BUSY, 0);
      chk(nmov - n0, 1);
      apb(0, `CLPV_ADDR_ENC_POS, 0); chk(rd, enc_exp(sc[i], t));
      apb(0, `CLPV_ADDR_ABS_POS, 0); chk(rd, t);
    end
    apb(1, `CLPV_ADDR_EXEC_FMT, 32'h100);
    #1 chk(motion_enable, 0);
    n0 = nmov;
    move(32'h20);
    repeat (10) @(posedge pclk);
    chk(nmov - n0, 0);
    apb(1, `CLPV_ADDR_EXEC_FMT, 32'h0);
    #1 chk(motion_enable, 1);
    // Mode 1 ends on the first fault; mode 2 with two attempts retries twice
    for (i = 1; i < 3; i++) begin
      home();
      apb(1, `CLPV_ADDR_RETRY_MS, 32'h3);
      apb(1, `CLPV_ADDR_ATTEMPTS, 32'h2);
      cyc_kind <= 1; @(posedge pclk); cyc_kind <= 0;
      apb(1, `CLPV_ADDR_MODE, i);
      n0 = nmov; h0 = nhalt; slip <= 1;
      move(32'h64);
      wst(`CLPV_ST_CL_ERR, 1);
      chk(nhalt - h0, (i == 1) ? 1 : 3);
      chk(nmov - n0, (i == 1) ? 1 : 3);
      chk(fault, 1);
      apb(0, `CLPV_ADDR_ABS_POS, 0); t = rd;
      apb(0, `CLPV_ADDR_ENC_POS, 0); chk(t, rd);
      apb(0, `CLPV_ADDR_ATT_LEFT, 0); chk(rd, (i == 1) ? 2 : 0);
      cyc_kind <= 1; @(posedge pclk); cyc_kind <= 0;
      apb(0, `CLPV_ADDR_ATT_LEFT, 0); chk(rd, 2);
      slip <= 0;
      apb(1, `CLPV_ADDR_CMD, 32'h1);
      apb(0, `CLPV_ADDR_STATUS, 0); chk(rd[`CLPV_ST_CL_ERR], 0);
      chk(fault, 0);
    end
    home();
    apb(1, `CLPV_ADDR_MODE, 32'h3);
    n0 = nmov;
    kick <= 1; repeat (8) @(posedge pclk); kick <= 0;
    for (i = 0; i < 300 && nmov == n0; i++) @(posedge pclk);
    if (nmov == n0) err_count++;
    // Correction fires on the first count past the deadband, not after all kicks
    #1 chk(move_target, `CLPV_RST_DEADBAND + 1);
    apb(1, `CLPV_ADDR_MODE, 32'h0);
    wst(`CLPV_ST_BUSY, 0);
    final_report();
  end
endmodule // tb_top
